//--- apcf_assertions.sv
/* checker on apcf_top ports.
 assumes a bind from the bench top file and a single clock. */
`timescale 1ns/100ps
module apcf_assertions (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire apcf_pkg::apcf_wb_req_t wb_req,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic port_a_master,
    input wire logic port_a_frame_clock,
    input wire logic port_a_bit_clock,
    input wire logic port_b_clock_master_sel,
    input wire logic port_b_clocks_from_port_a,
    input wire logic port_b_output_silence,
    input wire logic [2:0] port_b_format_sel,
    input wire logic port_b_i2s_format,
    input wire logic port_b_serial_out
);
    // ----------------
    // one domain only
    // ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_slave_quiet: assert property (!port_a_master [*2]
        |-> !port_a_frame_clock && !port_a_bit_clock) else $error("clock in slave");
    a_ack_answer: assert property (clk_en && wb_req.cyc && wb_req.stb && !wb_ack_o
        |=> wb_ack_o) else $error("no ack");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    a_a_top_zero: assert property (wb_ack_o && wb_req.adr == 8'h04
        |-> wb_dat_o[31:4] == 28'h0) else $error("a top bits");
    a_b_top_zero: assert property (wb_ack_o && wb_req.adr == 8'h05
        |-> wb_dat_o[31:7] == 25'h0) else $error("b top bits");
    a_i2s_code: assert property (port_b_i2s_format == (port_b_format_sel == 3'h1))
        else $error("i2s flag");
    a_ms_same: assert property (port_b_clocks_from_port_a == port_b_clock_master_sel)
        else $error("master sel");
    a_mute_low: assert property (port_b_output_silence [*2] |-> !port_b_serial_out)
        else $error("mute");
    c_frame: cover property ($rose(port_a_frame_clock));
    c_i2s: cover property (port_b_i2s_format);
    c_mute: cover property (port_b_output_silence);
endmodule

//--- apcf_cfg.svh
/*
 holds offsets, field positions, reset values and counts for the audio
 port clock and format configuration block as macros.
 assumes it is included by its bare name after nothing else.
*/
`ifndef APCF_CFG_SVH
`define APCF_CFG_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define APCF_PORT_A_CLOCK_SETUP_OFS 8'h04
`define APCF_PORT_B_PRIMARY_SETUP_OFS 8'h05
`define APCF_A_STATUS_OFS 8'h08

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define APCF_A_DIV_LSB 0
`define APCF_A_SRC_LSB 2
`define APCF_B_FMT_LSB 0
`define APCF_B_MS_BIT 3
`define APCF_B_OSRC_LSB 4
`define APCF_B_SILENCE_BIT 6
`define APCF_A_RESET 8'h00
`define APCF_B_RESET 8'h00

// ------------------------------------------------------------
// clock figures
// ------------------------------------------------------------
`define APCF_BITS_PER_FRAME 10'h040
`define APCF_DIV_128 10'h080
`define APCF_DIV_256 10'h100
`define APCF_DIV_384 10'h180
`define APCF_DIV_512 10'h200

`endif

//--- apcf_partner.sv
/* far-side converter model: clock candidates and audio bits.
 assumes the bench clock; outputs move just after its rising edge. */
`timescale 1ns/100ps
module apcf_partner (
    input wire logic clk,
    output logic mclk,
    output logic rx_clk,
    output logic rec_clk,
    output apcf_pkg::apcf_audio_in_t audio
);
    logic [7:0] cnt_reg = 8'h00;
    // periods of 8, 16 and 32 cycles so a wrong source shows in the frame period
    always_ff @(posedge clk) cnt_reg <= cnt_reg + 8'h01;
    assign mclk = cnt_reg[2];
    assign rx_clk = cnt_reg[3];
    assign rec_clk = cnt_reg[4];
    // the port a and port b bits differ every cycle and the receiver bit toggles every two, so a wrong route cannot hide
    assign audio = {cnt_reg[0], ~cnt_reg[0], cnt_reg[1]};
endmodule

//--- apcf_pkg.sv
/*
 holds the types of the audio port clock and format configuration block.
 assumes apcf_cfg.svh is compiled alongside.
*/
package apcf_pkg;

    // port a master clock sources; reserved code falls back to the default
    typedef enum logic [1:0] {
        APCF_SRC_MCLK = 2'h0,
        APCF_SRC_RECEIVER_CLOCK_INPUT = 2'h1,
        APCF_SRC_RECOVERED_RECEIVER_CLOCK = 2'h2,
        APCF_SRC_RSVD = 2'h3
    } apcf_src_t;

    // classic wishbone request
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } apcf_wb_req_t;

    // audio sample inputs, one bit per port
    typedef struct packed {
        logic port_a_in;
        logic port_b_in;
        logic receiver_in;
    } apcf_audio_in_t;

    // whole state of the block
    typedef struct packed {
        logic [7:0] a_setup;
        logic [7:0] b_setup;
        logic [31:0] rdat;
        logic ack;
        logic [9:0] div_cnt;
        logic [5:0] bit_cnt;
        logic bit_clk;
        logic frame_clk;
        logic serial_out;
        logic [2:0] src_prev;
        logic [2:0] src_cur;
    } apcf_state_t;

endpackage

//--- apcf_top.sv
/*
 audio port clock and format configuration: holds the port a clock setup
 and port b primary setup registers behind a classic wishbone slave,
 makes port a master frame and bit clocks, and steers port b output.
 assumes a single 250 MHz clock; all clock candidate inputs and audio
 inputs are synchronous to clk and sampled here as clock-enable levels.
*/
// The Wishbone slave port was chosen for this implementation.
// Summary of operation
// - In master mode port a frame clock is the chosen clock divided by 128, 256, 384 or 512.
// - In master mode port a bit clock runs at 64 times the frame clock for every divider.
// - The clock source field picks master clock, receiver clock or recovered clock; 11 reserved.
// - Source and divider act on port a clocks only while port a is in master mode.
// - Port a clock setup holds source in bits 3:2, divider in 1:0, and bits 7:4 read zero.
// - Port b setup holds zero, silence, output source, master select and format in bits 7..0.
// - Port b format 000 is 24-bit left-justified, 001 is 24-bit i2s, 010 is unused.
// - Port b clocks come from outside at master select 0 and from port a's source at 1.
// - Port b output source picks own input, port a input or the receiver; 11 reserved.
`timescale 1ns/100ps
`include "apcf_cfg.svh"

module apcf_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire apcf_pkg::apcf_wb_req_t wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic port_a_master,
    input wire logic master_clock_in,
    input wire logic receiver_clock_input,
    input wire logic recovered_receiver_clock,
    input wire apcf_pkg::apcf_audio_in_t audio_in,
    output logic port_a_frame_clock,
    output logic port_a_bit_clock,
    output logic port_a_clocks_active,
    output logic port_b_clock_master_sel,
    output logic port_b_clocks_from_port_a,
    output logic port_b_output_silence,
    output logic [2:0] port_b_format_sel,
    output logic port_b_i2s_format,
    output logic port_b_serial_out
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // divider code to half of the bit clock period in source edges
    function automatic logic [9:0] half_bit(input logic [1:0] code);
        logic [9:0] div;
        case (code)
            2'h0: div = `APCF_DIV_128;
            2'h1: div = `APCF_DIV_256;
            2'h2: div = `APCF_DIV_384;
            default: div = `APCF_DIV_512;
        endcase
        half_bit = 10'((div / `APCF_BITS_PER_FRAME) >> 1);
    endfunction

    // byte lane of the register word, honouring the low select line
    function automatic logic lane0_write(input apcf_pkg::apcf_wb_req_t r, input logic [7:0] ofs);
        lane0_write = r.cyc && r.stb && r.we && r.sel[0] && (r.adr == ofs);
    endfunction

    apcf_pkg::apcf_state_t st_reg;
    apcf_pkg::apcf_state_t st_next;
    apcf_pkg::apcf_src_t src_sel;
    logic src_level;
    logic src_rise;
    logic bsrc;
    logic [1:0] div_code;

    // ------------------------------------------------------------
    // clock source pick
    // ------------------------------------------------------------
    // reserved source code runs as the master clock input
    always_comb begin
        src_sel = apcf_pkg::apcf_src_t'(st_reg.a_setup[`APCF_A_SRC_LSB +: 2]);
        case (src_sel)
            apcf_pkg::APCF_SRC_RECEIVER_CLOCK_INPUT: src_level = receiver_clock_input;
            apcf_pkg::APCF_SRC_RECOVERED_RECEIVER_CLOCK: src_level = recovered_receiver_clock;
            default: src_level = master_clock_in;
        endcase
        div_code = st_reg.a_setup[`APCF_A_DIV_LSB +: 2];
        src_rise = src_level && !st_reg.src_cur[0];
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.src_cur = {st_reg.src_cur[1:0], src_level};
        st_next.src_prev = st_reg.src_cur;
        // wishbone: answer one cycle after the strobe, drop ack after one cycle
        st_next.ack = wb_req.cyc && wb_req.stb && !st_reg.ack;
        if (wb_req.cyc && wb_req.stb && !st_reg.ack) begin
            case (wb_req.adr)
                `APCF_PORT_A_CLOCK_SETUP_OFS: st_next.rdat = {24'h0, st_reg.a_setup};
                `APCF_PORT_B_PRIMARY_SETUP_OFS: st_next.rdat = {24'h0, st_reg.b_setup};
                `APCF_A_STATUS_OFS: st_next.rdat = {29'h0, port_a_master,
                    st_reg.frame_clk, st_reg.bit_clk};
                default: st_next.rdat = 32'h0;
            endcase
            if (lane0_write(wb_req, `APCF_PORT_A_CLOCK_SETUP_OFS)) begin
                st_next.a_setup = {4'h0, wb_req.dat[3:0]};
            end
            if (lane0_write(wb_req, `APCF_PORT_B_PRIMARY_SETUP_OFS)) begin
                st_next.b_setup = {1'b0, wb_req.dat[6:0]};
            end
        end
        // port a master clocks; counting stops and clocks park low in slave mode
        if (!port_a_master) begin
            st_next.div_cnt = 10'h0;
            st_next.bit_cnt = 6'h0;
            st_next.bit_clk = 1'b0;
            st_next.frame_clk = 1'b0;
        end else if (src_rise) begin
            if (st_reg.div_cnt + 10'h1 >= half_bit(div_code)) begin
                st_next.div_cnt = 10'h0;
                st_next.bit_clk = !st_reg.bit_clk;
                // 64 bit clock half periods per frame half: 64 bits a frame,
                // so the frame period is the full divider count of source edges
                st_next.bit_cnt = st_reg.bit_cnt + 6'h1;
                if (st_reg.bit_cnt == 6'h3f) begin
                    st_next.frame_clk = !st_reg.frame_clk;
                end
            end else begin
                st_next.div_cnt = st_reg.div_cnt + 10'h1;
            end
        end
        // port b output data path
        if (st_reg.b_setup[`APCF_B_SILENCE_BIT]) begin
            st_next.serial_out = 1'b0;
        end else begin
            st_next.serial_out = bsrc;
        end
    end

    // ------------------------------------------------------------
    // port b output source
    // ------------------------------------------------------------
    // reserved code falls back to loopback so the pin never floats
    always_comb begin
        case (st_reg.b_setup[`APCF_B_OSRC_LSB +: 2])
            2'h1: bsrc = audio_in.port_a_in;
            2'h2: bsrc = audio_in.receiver_in;
            default: bsrc = audio_in.port_b_in;
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.a_setup <= `APCF_A_RESET;
            st_reg.b_setup <= `APCF_B_RESET;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.rdat;
    assign port_a_frame_clock = st_reg.frame_clk;
    assign port_a_bit_clock = st_reg.bit_clk;
    assign port_a_clocks_active = port_a_master;
    assign port_b_clock_master_sel = st_reg.b_setup[`APCF_B_MS_BIT];
    assign port_b_clocks_from_port_a = st_reg.b_setup[`APCF_B_MS_BIT];
    assign port_b_output_silence = st_reg.b_setup[`APCF_B_SILENCE_BIT];
    assign port_b_format_sel = st_reg.b_setup[`APCF_B_FMT_LSB +: 3];
    // unused and reserved format codes run as left-justified
    assign port_b_i2s_format = (port_b_format_sel == 3'h1);
    assign port_b_serial_out = st_reg.serial_out;

endmodule

//--- tb_audio_port_clock_format_config.sv
/* bench for apcf_top: register, clock and port b scenarios.
 assumes apcf_partner supplies clock candidates and audio bits. */
`timescale 1ns/100ps
module tb_audio_port_clock_format_config;
    apcf_pkg::apcf_wb_req_t req = '0;
    apcf_pkg::apcf_audio_in_t au;
    logic clk, mc, rc, rk, ack, fclk, bclk, act, msel, mfrom, mute, i2s, sout;
    logic arst_n = 1'b0;
    logic master = 1'b1;
    logic [2:0] fmt;
    logic [31:0] rdat, q;
    int num_errors = 0;
    int check_count = 0;
    apcf_partner far_u (.clk(clk), .mclk(mc), .rx_clk(rc), .rec_clk(rk), .audio(au));
    apcf_top dut_u (.clk(clk), .arst_n(arst_n), .clk_en(1'b1), .wb_req(req),
        .wb_dat_o(rdat), .wb_ack_o(ack), .port_a_master(master), .master_clock_in(mc),
        .receiver_clock_input(rc), .recovered_receiver_clock(rk), .audio_in(au),
        .port_a_frame_clock(fclk), .port_a_bit_clock(bclk), .port_a_clocks_active(act),
        .port_b_clock_master_sel(msel), .port_b_clocks_from_port_a(mfrom),
        .port_b_output_silence(mute), .port_b_format_sel(fmt),
        .port_b_i2s_format(i2s), .port_b_serial_out(sout));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ack is sampled at the rising edge; the request stands until that edge
    task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
        logic got;
        got = 1'b0;
        @(posedge clk);
        req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
        for (int n = 0; n < 40 && !got; n++) begin
            @(posedge clk);
            if (ack === 1'b1) begin
                got = 1'b1;
                q = rdat;
            end
        end
        req <= '0;
        if (!got) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            wrap_up();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    task automatic t_regs();
        rd(8'h04, 32'h0);
        rd(8'h05, 32'h0);
        xfer(1'b1, 8'h04, 8'hff);
        rd(8'h04, 32'h0f);
        xfer(1'b1, 8'h05, 8'hff);
        rd(8'h05, 32'h7f);
        chk({mute, msel, fmt}, 32'h1f);
        xfer(1'b1, 8'h21, 8'hff);
        rd(8'h21, 32'h0);
        $display("test regs done");
    endtask
    // frame period from rise to rise, bit clock rises counted inside it
    task automatic measure(input int exp);
        int n, b, e, t;
        logic pf, pb;
        n = 0;
        b = 0;
        e = 0;
        pf = fclk;
        pb = bclk;
        for (t = 0; t < 40000 && e < 2; t++) begin
            @(negedge clk);
            n += (e == 1);
            b += (e == 1 && bclk && !pb);
            e += (fclk && !pf);
            pf = fclk;
            pb = bclk;
        end
        chk(n, exp);
        chk(b, 64);
    endtask
    task automatic t_clk();
        int per [7] = '{1024, 2048, 3072, 4096, 2048, 4096, 1024};
        logic [7:0] cfg [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0c};
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, 8'h04, cfg[i]);
            measure(per[i]);
        end
        $display("test clocks done");
    endtask
    task automatic t_slave();
        @(posedge clk) master <= 1'b0;
        repeat (300) @(negedge clk);
        chk({fclk, bclk, act}, 32'h0);
        @(posedge clk) master <= 1'b1;
        @(negedge clk);
        chk(act, 1'b1);
        $display("test slave done");
    endtask
    task automatic t_b();
        logic e;
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, 8'h05, {2'h0, i[1:0], i[0], i[2:0]});
            chk(i2s, i == 1);
            chk(mfrom, i[0]);
            repeat (4) begin
                @(negedge clk);
                e = i == 1 ? au.port_a_in : i == 2 ? au.receiver_in : au.port_b_in;
                @(negedge clk);
                chk(sout, e);
            end
        end
        xfer(1'b1, 8'h05, 8'h40);
        repeat (8) begin
            @(negedge clk);
            chk(sout, 1'b0);
        end
        $display("test port b done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_clk();
        t_slave();
        t_b();
        wrap_up();
    end
endmodule
bind apcf_top apcf_assertions chk_u (.*);
